/* core/rtcc_pkg.sv */
package rtcc_pkg;
	// Internal register addresses
	localparam logic [3:0] ADDR_SNAP0    = 4'h0;
	localparam logic [3:0] ADDR_SNAP3    = 4'h3;
	localparam logic [3:0] ADDR_REQUEST  = 4'h4;
	localparam logic [3:0] ADDR_OSC_CTL  = 4'h5;
	localparam logic [3:0] ADDR_LOAD_CFG = 4'h6;
	localparam logic [3:0] ADDR_ALARM0   = 4'h8;
	localparam logic [3:0] ADDR_ALARM3   = 4'hB;
	// Oscillator control field positions
	localparam int BIT_GAIN    = 7;
	localparam int BIT_CRYSTAL = 6;
	localparam int BIT_BIAS2   = 5;
	localparam int BIT_VALID   = 4;
	localparam int BIT_LFO     = 3;
	// Load configuration field positions
	localparam int BIT_AUTOSTEP = 7;
	localparam int BIT_CAPRDY   = 6;
	localparam int CAP_W        = 4;
	// Request register field positions
	localparam int BIT_LOAD_REQ = 1;
	localparam int BIT_SNAP_REQ = 0;
	// Reset values and address increment
	localparam logic [7:0]       RST_BYTE = 8'h00;
	localparam logic [CAP_W-1:0] RST_CAP  = 4'h0;
	localparam logic [3:0]       ADDR_INC = 4'h1;
	// Oscillator settings driven to the analog macro
	typedef struct packed {
		logic             gain_control_enable;
		logic             crystal_mode_select;
		logic             bias_double_enable;
		logic             internal_low_freq_oscillator;
		logic             load_cap_auto_step_enable;
		logic [CAP_W-1:0] load_cap_setting;
	} rtcc_osc_t;
	// Transfer sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_XFER = 2'b10
	} rtcc_state_t;
endpackage

/* core/rtcc_core.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcc_core #(
	parameter int TIMER_W = 32
) (
	input  wire logic               clk,
	input  wire logic               reset_n,
	input  wire logic               addr_wr,
	input  wire logic [7:0]         addr_wdata,
	output logic      [7:0]         indirect_address_register,
	input  wire logic               data_wr,
	input  wire logic [7:0]         data_wdata,
	input  wire logic               data_rd,
	output logic      [7:0]         indirect_data_register,
	input  wire logic               oscillation_valid,
	input  wire logic [TIMER_W-1:0] timer_count,
	output logic                    timer_load_strobe,
	output logic      [TIMER_W-1:0] timer_load_value,
	output rtcc_pkg::rtcc_osc_t     osc_settings
);
	import rtcc_pkg::*;

	localparam int NBYTES = TIMER_W / 8;

	// Only a four-byte timer fits the snapshot address window
	if (TIMER_W != 32) begin : g_bad_width
		$error("rtcc_core: TIMER_W must be 32");
	end

	logic [7:0]         addr_reg, addr_next;       // Indirect address
	logic [7:0]         data_reg, data_next;       // Indirect data byte
	logic [7:0]         snap_reg [NBYTES];         // Timer snapshot bytes
	logic [7:0]         snap_next [NBYTES];
	logic [1:0]         req_reg, req_next;         // Load and snapshot requests
	rtcc_state_t        state_reg, state_next;     // Transfer sequencer
	logic               gain_reg, gain_next;
	logic               xtal_reg, xtal_next;
	logic               bias_reg, bias_next;
	logic               lfo_reg, lfo_next;
	logic               step_reg, step_next;
	logic [CAP_W-1:0]   target_reg, target_next;   // Programmed capacitance
	logic [CAP_W-1:0]   actual_reg, actual_next;   // Capacitance now applied
	logic               strobe_reg, strobe_next;
	logic [TIMER_W-1:0] loadv_reg, loadv_next;
	logic [3:0]         sel;                       // Selected internal register
	logic               auto_inc;                  // Access walks the address
	logic [7:0]         rd_byte;                   // Byte of selected register

	assign sel = addr_reg[3:0];
	// Snapshot and alarm windows advance the address after each access
	assign auto_inc = (sel <= ADDR_SNAP3) || (sel >= ADDR_ALARM0 && sel <= ADDR_ALARM3);

	// Read multiplexer; reserved and unmapped bits read zero
	always_comb begin
		rd_byte = RST_BYTE;
		if (sel <= ADDR_SNAP3) begin
			rd_byte = snap_reg[sel[1:0]];
		end else if (sel == ADDR_REQUEST) begin
			rd_byte[1:0] = req_reg;
		end else if (sel == ADDR_OSC_CTL) begin
			rd_byte[BIT_GAIN]    = gain_reg;
			rd_byte[BIT_CRYSTAL] = xtal_reg;
			rd_byte[BIT_BIAS2]   = bias_reg;
			rd_byte[BIT_VALID]   = oscillation_valid;
			rd_byte[BIT_LFO]     = lfo_reg;
		end else if (sel == ADDR_LOAD_CFG) begin
			rd_byte[BIT_AUTOSTEP]  = step_reg;
			rd_byte[BIT_CAPRDY]    = (actual_reg == target_reg);
			rd_byte[CAP_W-1:0]     = target_reg;
		end
	end

	// Next-state logic for all register state
	always_comb begin
		addr_next   = addr_reg;
		data_next   = data_reg;
		snap_next   = snap_reg;
		req_next    = req_reg;
		state_next  = state_reg;
		gain_next   = gain_reg;
		xtal_next   = xtal_reg;
		bias_next   = bias_reg;
		lfo_next    = lfo_reg;
		step_next   = step_reg;
		target_next = target_reg;
		actual_next = actual_reg;
		strobe_next = 1'b0;
		loadv_next  = loadv_reg;
		// Address register write
		if (addr_wr) begin
			addr_next = addr_wdata;
		end else if ((data_wr || data_rd) && auto_inc) begin
			addr_next[3:0] = sel + ADDR_INC;
		end
		// Indirect read latches the selected byte into the data register
		if (data_rd) begin
			data_next = rd_byte;
		end
		// Indirect write stores the byte and forwards it to the target
		if (data_wr) begin
			data_next = data_wdata;
			if (sel <= ADDR_SNAP3) begin
				snap_next[sel[1:0]] = data_wdata;
			end else if (sel == ADDR_REQUEST) begin
				req_next[BIT_LOAD_REQ] = req_reg[BIT_LOAD_REQ] | data_wdata[BIT_LOAD_REQ];
				req_next[BIT_SNAP_REQ] = req_reg[BIT_SNAP_REQ] | data_wdata[BIT_SNAP_REQ];
			end else if (sel == ADDR_OSC_CTL) begin
				gain_next = data_wdata[BIT_GAIN];
				xtal_next = data_wdata[BIT_CRYSTAL];
				bias_next = data_wdata[BIT_BIAS2];
				lfo_next  = data_wdata[BIT_LFO];
			end else if (sel == ADDR_LOAD_CFG) begin
				step_next   = data_wdata[BIT_AUTOSTEP];
				target_next = data_wdata[CAP_W-1:0];
			end
		end
		// Capacitance walks one code per cycle when stepping, else jumps
		if (!step_reg) begin
			actual_next = target_reg;
		end else if (actual_reg < target_reg) begin
			actual_next = actual_reg + 1'b1;
		end else if (actual_reg > target_reg) begin
			actual_next = actual_reg - 1'b1;
		end
		// Transfer sequencer
		unique case (state_reg)
			ST_IDLE: begin
				if (req_reg != 2'b00) begin
					state_next = ST_XFER;
				end
			end
			ST_XFER: begin
				if (req_reg[BIT_LOAD_REQ]) begin
					for (int i = 0; i < NBYTES; i++) begin
						loadv_next[i*8 +: 8] = snap_reg[i];
					end
					strobe_next = 1'b1;
				end
				if (req_reg[BIT_SNAP_REQ]) begin
					for (int i = 0; i < NBYTES; i++) begin
						snap_next[i] = timer_count[i*8 +: 8];
					end
				end
				// Hardware clear; a request written in this same cycle wins
				req_next[BIT_LOAD_REQ] = data_wr && (sel == ADDR_REQUEST) && data_wdata[BIT_LOAD_REQ];
				req_next[BIT_SNAP_REQ] = data_wr && (sel == ADDR_REQUEST) && data_wdata[BIT_SNAP_REQ];
				state_next = ST_IDLE;
			end
		endcase
	end

	// Register stage
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			addr_reg   <= RST_BYTE;
			data_reg   <= RST_BYTE;
			for (int i = 0; i < NBYTES; i++) begin
				snap_reg[i] <= RST_BYTE;
			end
			req_reg    <= 2'b00;
			state_reg  <= ST_IDLE;
			gain_reg   <= 1'b0;
			xtal_reg   <= 1'b0;
			bias_reg   <= 1'b0;
			lfo_reg    <= 1'b0;
			step_reg   <= 1'b0;
			target_reg <= RST_CAP;
			actual_reg <= RST_CAP;
			strobe_reg <= 1'b0;
			loadv_reg  <= '0;
		end else begin
			addr_reg   <= addr_next;
			data_reg   <= data_next;
			snap_reg   <= snap_next;
			req_reg    <= req_next;
			state_reg  <= state_next;
			gain_reg   <= gain_next;
			xtal_reg   <= xtal_next;
			bias_reg   <= bias_next;
			lfo_reg    <= lfo_next;
			step_reg   <= step_next;
			target_reg <= target_next;
			actual_reg <= actual_next;
			strobe_reg <= strobe_next;
			loadv_reg  <= loadv_next;
		end
	end

	// Outputs; internal oscillator overrides the crystal select
	assign indirect_address_register = addr_reg;
	assign indirect_data_register    = data_reg;
	assign timer_load_strobe         = strobe_reg;
	assign timer_load_value          = loadv_reg;
	assign osc_settings.gain_control_enable          = gain_reg;
	assign osc_settings.crystal_mode_select          = xtal_reg & ~lfo_reg;
	assign osc_settings.bias_double_enable           = bias_reg;
	assign osc_settings.internal_low_freq_oscillator = lfo_reg;
	assign osc_settings.load_cap_auto_step_enable    = step_reg;
	assign osc_settings.load_cap_setting             = actual_reg;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_req_done: assert property (req_reg != 2'b00 |-> ##[1:2] req_reg == 2'b00)
		else $error("request bit did not self-clear");
	a_load_pulse: assert property ($rose(req_reg[BIT_LOAD_REQ]) |-> ##2 timer_load_strobe)
		else $error("load strobe missing after load request");
	a_load_only: assert property (timer_load_strobe |-> $past(state_reg == ST_XFER))
		else $error("timer load without request");
	a_load_bytes: assert property (timer_load_strobe |-> timer_load_value[7:0] == $past(snap_reg[0]))
		else $error("low byte not taken from address zero");
	a_snap_take: assert property (state_reg == ST_XFER && req_reg[BIT_SNAP_REQ] |=> snap_reg[0] == $past(timer_count[7:0]))
		else $error("snapshot did not copy timer");
	a_addr_walk: assert property (data_wr && !addr_wr && sel == ADDR_SNAP0 |=> sel == ADDR_SNAP0 + ADDR_INC)
		else $error("address did not increment");
	a_addr_hold: assert property (data_wr && !addr_wr && sel == ADDR_OSC_CTL |=> sel == ADDR_OSC_CTL)
		else $error("address moved on oscillator access");
	a_lfo_override: assert property (lfo_reg |-> !osc_settings.crystal_mode_select)
		else $error("crystal selected while internal oscillator on");
	a_gain_write: assert property (data_wr && !addr_wr && sel == ADDR_OSC_CTL |=> osc_settings.gain_control_enable == $past(data_wdata[BIT_GAIN]))
		else $error("gain enable not written");
	a_data_read: assert property (data_rd && sel == ADDR_OSC_CTL |=> indirect_data_register[BIT_VALID] == $past(oscillation_valid))
		else $error("valid bit misread");
	a_cap_jump: assert property (!step_reg |=> actual_reg == $past(target_reg))
		else $error("capacitance not applied directly");

	c_load: cover property (timer_load_strobe);
	c_snap: cover property (state_reg == ST_XFER && req_reg[BIT_SNAP_REQ]);
	c_step: cover property (step_reg && actual_reg != target_reg ##1 actual_reg == target_reg);
	c_walk: cover property (data_rd && sel == ADDR_SNAP3);
endmodule
`default_nettype wire

/* tb/rtcc_core_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcc_core_tb;
	import rtcc_pkg::*;
	logic                 clk;                       // 25 MHz bench clock
	logic                 reset_n;                   // Active-low reset
	logic                 addr_wr;                   // Address write strobe
	logic [7:0]           addr_wdata;                // Address byte
	logic                 data_wr;                   // Data write strobe
	logic [7:0]           data_wdata;                // Data byte
	logic                 data_rd;                   // Data read strobe
	logic                 oscillation_valid;         // Amplitude flag from analog
	logic [31:0]          timer_count;               // Running timer
	logic [7:0]           indirect_address_register; // Current address
	logic [7:0]           indirect_data_register;    // Data register
	logic                 timer_load_strobe;         // Timer load pulse
	logic [31:0]          timer_load_value;          // Value to load
	rtcc_osc_t            osc_settings;              // Analog settings
	int                   fail_count;                // Mismatches
	int                   checks;                    // Comparisons made
	int                   loads;                     // Load pulses seen
	logic [7:0]           got;                       // Last read byte
	rtcc_core rtcc_core_i (.clk(clk), .reset_n(reset_n), .addr_wr(addr_wr),
		.addr_wdata(addr_wdata), .indirect_address_register(indirect_address_register),
		.data_wr(data_wr), .data_wdata(data_wdata), .data_rd(data_rd),
		.indirect_data_register(indirect_data_register), .oscillation_valid(oscillation_valid),
		.timer_count(timer_count), .timer_load_strobe(timer_load_strobe),
		.timer_load_value(timer_load_value), .osc_settings(osc_settings));
	// Clock generator
	always #20 clk = ~clk;
	// Counts every load pulse so stray transfers show up
	always @(posedge clk) begin
		if (timer_load_strobe === 1'b1) loads++;
	end
	// Verdict and end of run
	task automatic conclude;
		if (fail_count == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Byte and word comparisons
	task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Access cycles: strobe for one edge, then release
	task automatic wr_addr(input logic [7:0] a);
		@(posedge clk) begin addr_wr <= 1'b1; addr_wdata <= a; end
		@(posedge clk) addr_wr <= 1'b0;
		#1;
	endtask
	task automatic wr_data(input logic [7:0] d);
		@(posedge clk) begin data_wr <= 1'b1; data_wdata <= d; end
		@(posedge clk) data_wr <= 1'b0;
		#1;
	endtask
	task automatic rd_data(output logic [7:0] d);
		@(posedge clk) data_rd <= 1'b1;
		@(posedge clk) data_rd <= 1'b0;
		#1 d = indirect_data_register;
	endtask
	// Select an address, read it and compare
	task automatic rreg(input logic [7:0] a, input logic [7:0] e);
		wr_addr(a);
		rd_data(got);
		cmp8(got, e);
	endtask
	// Hang guard
	initial begin
		#100000;
		fail_count++;
		conclude();
	end
	// Main sequence
	initial begin
		clk = 1'b0; reset_n = 1'b0; addr_wr = 1'b0; addr_wdata = 8'h00; data_wr = 1'b0;
		data_wdata = 8'h00; data_rd = 1'b0; oscillation_valid = 1'b0;
		timer_count = 32'h0000_0000; fail_count = 0; checks = 0; loads = 0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		rreg(8'h05, 8'h00);
		cmp32({23'h0, osc_settings}, 32'h0);
		rreg(8'h07, 8'h00);
		// Oscillator control: gain, bias, internal source overriding crystal
		wr_addr(8'h05);
		wr_data(8'hE8);
		@(posedge clk) oscillation_valid <= 1'b1;
		rd_data(got);
		cmp8(got, 8'hF8);
		cmp32({23'h0, osc_settings}, 32'h160);
		cmp8(indirect_address_register, 8'h05);
		wr_data(8'h40);
		@(posedge clk) oscillation_valid <= 1'b0;
		rd_data(got);
		cmp8(got, 8'h40);
		cmp32({23'h0, osc_settings}, 32'h080);
		// Load capacitance: direct, then stepped
		wr_addr(8'h06);
		wr_data(8'h09);
		rd_data(got);
		cmp8(got, 8'h49);
		cmp32({23'h0, osc_settings}, 32'h089);
		wr_data(8'h8F);
		rd_data(got);
		cmp8(got, 8'h8F);
		repeat (8) @(posedge clk);
		rd_data(got);
		cmp8(got, 8'hCF);
		cmp32({23'h0, osc_settings}, 32'h09F);
		// Snapshot bytes with address auto-increment
		wr_addr(8'h00);
		wr_data(8'h11);
		wr_data(8'h22);
		wr_data(8'h33);
		wr_data(8'h44);
		cmp8(indirect_address_register, 8'h04);
		@(posedge clk) timer_count <= 32'hCAFE_1234;
		rreg(8'h00, 8'h11);
		cmp32(loads, 0);
		// Timer load request, self-clearing
		wr_addr(8'h04);
		wr_data(8'h02);
		for (int i = 0; i < 10 && timer_load_strobe !== 1'b1; i++) @(posedge clk) #1;
		cmp32(timer_load_value, 32'h4433_2211);
		rd_data(got);
		cmp8(got, 8'h00);
		cmp8(indirect_address_register, 8'h04);
		// Timer snapshot request, polled to completion
		wr_data(8'h01);
		for (int i = 0; i < 10; i++) begin
			rd_data(got);
			if (got === 8'h00) break;
		end
		cmp8(got, 8'h00);
		cmp32(loads, 1);
		wr_addr(8'h00);
		for (int k = 0; k < 32; k += 8) begin
			rd_data(got);
			cmp8(got, timer_count[k+:8]);
		end
		cmp8(indirect_address_register, 8'h04);
		// Alarm address increments in the low nibble, upper nibble kept
		wr_addr(8'h3B);
		wr_data(8'h5A);
		cmp8(indirect_address_register, 8'h3C);
		// Mid-run reset returns every register to its reset value
		@(posedge clk) reset_n <= 1'b0;
		@(posedge clk) reset_n <= 1'b1;
		#1 cmp8(indirect_address_register, 8'h00);
		cmp8(indirect_data_register, 8'h00);
		cmp32({23'h0, osc_settings}, 32'h0);
		rreg(8'h05, 8'h00);
		conclude();
	end
endmodule
`default_nettype wire
